// ---- core/csub_defines.svh ----
// Constants of the channel status and user bit buffer block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CSUB_DEFINES_SVH
`define CSUB_DEFINES_SVH

// Buffer geometry: one block of 192 frames times two subframes.
`define CSUB_BUF_BITS    384
`define CSUB_LAST_BIT    9'h17f
`define CSUB_FIX5_BITS   40

// Synchronised input bit positions.
`define CSUB_SYNC_W      7
`define CSUB_SY_CLK      0
`define CSUB_SY_SEL_N    1
`define CSUB_SY_DIN      2
`define CSUB_SY_SDA      3
`define CSUB_SY_I2C      4
`define CSUB_SY_RCLK     5
`define CSUB_SY_XCLK     6

// Serial chip address (arbitrary value, no meaning beyond this block).
`define CSUB_CHIP_ADDR   7'h10

// Register map, byte wide registers.
`define CSUB_A_CTRL      8'h00
`define CSUB_A_IRQFMT    8'h01
`define CSUB_A_STAT0     8'h02
`define CSUB_A_EN0       8'h03
`define CSUB_A_CLR0      8'h04
`define CSUB_A_STAT1     8'h05
`define CSUB_A_EN1       8'h06
`define CSUB_A_CLR1      8'h07
`define CSUB_A_STATE     8'h08
`define CSUB_A_WIN       8'h20
`define CSUB_A_WIN_END   8'h50

// Control register fields.
`define CSUB_CTRL_RUN    0
`define CSUB_CTRL_BUFFER_KIND_SELECT   1
`define CSUB_CTRL_FIX5   2
`define CSUB_CTRL_UHOLD  3
`define CSUB_CTRL_MASK   8'h0f

// Status bits.
`define CSUB_S0_DE       0
`define CSUB_S0_EF       1
`define CSUB_S1_REFUSED  0
`define CSUB_S1_REALIGN  1

// Interrupt output formats.
`define CSUB_IF_HIGH     2'h0
`define CSUB_IF_LOW      2'h1
`define CSUB_IF_OPEN     2'h2

`endif

// ---- core/csub_pkg.sv ----
// Types of the channel status and user bit buffer block.
// Assumes csub_defines.svh is on the include path.
`include "csub_defines.svh"

package csub_pkg;

    // Phase of a serial control transfer.
    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ADDR,
        SP_MAP,
        SP_DATA
    } csub_phase_t;

    // State of the three-stage input synchroniser.
    typedef struct packed {
        logic [`CSUB_SYNC_W-1:0] s1;
        logic [`CSUB_SYNC_W-1:0] s2;
        logic [`CSUB_SYNC_W-1:0] s3;
        logic [`CSUB_SYNC_W-1:0] q;
    } csub_sync_t;

    // Whole state of the buffer block.
    typedef struct packed {
        logic [`CSUB_BUF_BITS-1:0] d_cs;
        logic [`CSUB_BUF_BITS-1:0] d_us;
        logic [`CSUB_BUF_BITS-1:0] e_cs;
        logic [`CSUB_BUF_BITS-1:0] e_us;
        logic [`CSUB_BUF_BITS-1:0] f_cs;
        logic [`CSUB_BUF_BITS-1:0] f_us;
        logic [8:0]                rxp;
        logic                      rx_aligned;
        logic [8:0]                txp;
        logic                      tx_c;
        logic                      tx_u;
        logic [7:0]                ctrl;
        logic [1:0]                irqfmt;
        logic [7:0]                stat0;
        logic [7:0]                en0;
        logic [7:0]                stat1;
        logic [7:0]                en1;
        logic [7:0]                rdata;
        csub_phase_t               phase;
        logic [7:0]                sh;
        logic [3:0]                bitc;
        logic                      rw;
        logic                      ack_due;
        logic                      nack;
        logic [7:0]                map;
        logic [7:0]                txsh;
        logic                      ser_out;
        logic                      ser_oe;
        logic [`CSUB_SYNC_W-1:0]   prev;
        logic                      irq;
        logic                      irq_oe;
    } csub_state_t;

endpackage

// ---- core/csub_sync.sv ----
// Three-stage synchroniser for every input that comes from outside mclk.
// Assumes the inputs are plain levels; a change is accepted once stages two and three agree.
`include "csub_defines.svh"

module csub_sync (
    input  wire logic                    mclk_i,
    input  wire logic                    arst_n_i,
    input  wire logic [`CSUB_SYNC_W-1:0] async_i,
    output logic      [`CSUB_SYNC_W-1:0] level_o
);

    csub_pkg::csub_sync_t q;  // Registered synchroniser state.
    csub_pkg::csub_sync_t n;  // Next synchroniser state.

    // Stage one feeds only stage two; the filter compares stages two and three.
    always_comb begin
        n    = q;
        n.s1 = async_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        // A bit that still disagrees between the late stages keeps its old value.
        n.q  = (q.s2 & q.s3) | (q.q & (q.s2 | q.s3));
    end

    // Register the synchroniser state.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level_o = q.q;

endmodule

// ---- core/csub_top.sv ----
// Channel status and user bit buffers with their serial and parallel control access.
// Assumes the receive decoder and transmit encoder run on mclk_i; serial pins and clock-run flags are asynchronous.
//
// The address map and the plain strobed port are this design's own decisions.
`include "csub_defines.svh"

module csub_top (
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       ser_clk_i,
    input  wire logic       ser_sel_n_i,
    input  wire logic       ser_din_i,
    input  wire logic       ser_io_i,
    output logic            ser_io_o,
    output logic            ser_io_oe_o,
    input  wire logic       i2c_mode_i,
    input  wire logic       rclk_run_i,
    input  wire logic       xclk_run_i,
    input  wire logic       rx_bit_valid_i,
    input  wire logic       rx_block_first_i,
    input  wire logic       rx_cbit_i,
    input  wire logic       rx_ubit_i,
    input  wire logic       tx_bit_req_i,
    output logic            tx_cbit_o,
    output logic            tx_ubit_o,
    output logic            irq_o,
    output logic            irq_oe_o
);

    csub_pkg::csub_state_t   q;    // Registered block state.
    csub_pkg::csub_state_t   n;    // Next block state.
    logic [`CSUB_SYNC_W-1:0] sy;   // Filtered asynchronous inputs.

    // True when the address falls inside the buffer window.
    function automatic logic in_win(input logic [7:0] a);
        in_win = (a >= `CSUB_A_WIN) && (a < `CSUB_A_WIN_END);
    endfunction

    // Bit offset of a window byte inside a stage.
    function automatic logic [8:0] win_bit(input logic [7:0] a);
        logic [7:0] idx;
        idx     = a - `CSUB_A_WIN;
        win_bit = {idx[5:0], 3'h0};
    endfunction

    // Read value of one register; the window shows the selected E stage.
    function automatic logic [7:0] reg_read(input csub_pkg::csub_state_t s, input logic [7:0] a,
                                            input logic on);
        logic [7:0] v;
        v = 8'h00;
        if (in_win(a)) begin
            if (on) begin
                v = s.ctrl[`CSUB_CTRL_BUFFER_KIND_SELECT] ? s.e_us[win_bit(a) +: 8] : s.e_cs[win_bit(a) +: 8];
            end
        end else begin
            unique case (a)
                `CSUB_A_CTRL:   v = s.ctrl;
                `CSUB_A_IRQFMT: v = {6'h00, s.irqfmt};
                `CSUB_A_STAT0:  v = s.stat0;
                `CSUB_A_EN0:    v = s.en0;
                `CSUB_A_STAT1:  v = s.stat1;
                `CSUB_A_EN1:    v = s.en1;
                `CSUB_A_STATE:  v = {4'h0, s.rx_aligned, sy[`CSUB_SY_XCLK], sy[`CSUB_SY_RCLK], on};
                default:        v = 8'h00;
            endcase
        end
        reg_read = v;
    endfunction

    // Apply one register write; clear registers only clear, window writes need running clocks.
    function automatic csub_pkg::csub_state_t reg_write(input csub_pkg::csub_state_t s,
                                                        input logic [7:0] a, input logic [7:0] v,
                                                        input logic on);
        csub_pkg::csub_state_t r;
        r = s;
        if (in_win(a)) begin
            if (on && r.ctrl[`CSUB_CTRL_BUFFER_KIND_SELECT]) begin
                r.e_us[win_bit(a) +: 8] = v;
            end else if (on) begin
                r.e_cs[win_bit(a) +: 8] = v;
            end
        end else begin
            unique case (a)
                `CSUB_A_CTRL:   r.ctrl   = v & `CSUB_CTRL_MASK;
                `CSUB_A_IRQFMT: r.irqfmt = v[1:0];
                `CSUB_A_EN0:    r.en0    = v;
                `CSUB_A_CLR0:   r.stat0  = r.stat0 & ~v;
                `CSUB_A_EN1:    r.en1    = v;
                `CSUB_A_CLR1:   r.stat1  = r.stat1 & ~v;
                default:        r.ctrl   = r.ctrl;
            endcase
        end
        reg_write = r;
    endfunction

    // Serial pins and clock-run flags cross into mclk here; the host clock is only ever sampled.
    csub_sync u_sync (
        .mclk_i  (mclk_i),
        .arst_n_i(arst_n_i),
        .async_i ({xclk_run_i, rclk_run_i, i2c_mode_i, ser_io_i, ser_din_i, ser_sel_n_i, ser_clk_i}),
        .level_o (sy)
    );

    // Next-state logic for the serial engine, register access and the three buffer stages.
    always_comb begin
        logic       on;
        logic       i2c;
        logic       din;
        logic       clk_r;
        logic       clk_f;
        logic       start;
        logic       stop;
        logic       s_wr;
        logic       s_rd;
        logic [7:0] byte_in;
        logic [8:0] ptr;
        logic [7:0] ev0;
        logic [7:0] ev1;
        logic       pend;

        n       = q;
        ev0     = 8'h00;
        ev1     = 8'h00;
        s_wr    = 1'b0;
        s_rd    = 1'b0;
        ptr     = q.rxp;
        n.prev  = sy;
        // Buffers only work with both master clocks running and run set.
        on      = q.ctrl[`CSUB_CTRL_RUN] & sy[`CSUB_SY_RCLK] & sy[`CSUB_SY_XCLK];
        i2c     = sy[`CSUB_SY_I2C];
        din     = i2c ? sy[`CSUB_SY_SDA] : sy[`CSUB_SY_DIN];
        byte_in = {q.sh[6:0], din};
        // Edges of the host clock, found by sampling; the engine has no clock of its own.
        clk_r   = sy[`CSUB_SY_CLK] & ~q.prev[`CSUB_SY_CLK];
        clk_f   = ~sy[`CSUB_SY_CLK] & q.prev[`CSUB_SY_CLK];
        pend    = 1'b0;
        // Frame limits: chip select in SPI, start and stop conditions in I2C.
        start   = q.prev[`CSUB_SY_SEL_N] & ~sy[`CSUB_SY_SEL_N];
        stop    = ~q.prev[`CSUB_SY_SEL_N] & sy[`CSUB_SY_SEL_N];
        if (i2c) begin
            start = q.prev[`CSUB_SY_SDA] & ~sy[`CSUB_SY_SDA] & sy[`CSUB_SY_CLK] & q.prev[`CSUB_SY_CLK];
            stop  = ~q.prev[`CSUB_SY_SDA] & sy[`CSUB_SY_SDA] & sy[`CSUB_SY_CLK] & q.prev[`CSUB_SY_CLK];
        end

        // Serial engine: a stop always wins, a start restarts even mid-frame.
        if (stop) begin
            n.phase  = csub_pkg::SP_IDLE;
            n.bitc   = 4'h0;
            n.ser_oe = 1'b0;
        end else if (start) begin
            n.phase   = csub_pkg::SP_ADDR;
            n.bitc    = 4'h0;
            n.nack    = 1'b0;
            n.ack_due = 1'b0;
            n.ser_oe  = ~i2c;  // SPI drives its data pin for the whole select.
        end else if (q.phase != csub_pkg::SP_IDLE) begin
            if (clk_r) begin
                if (i2c && q.bitc == 4'h8) begin
                    // Acknowledge slot: a read ends once the host answers no.
                    n.bitc = 4'h0;
                    if (q.rw && q.phase == csub_pkg::SP_DATA && din) begin
                        n.nack = 1'b1;
                    end
                end else begin
                    n.sh   = byte_in;
                    n.bitc = q.bitc + 4'h1;
                    if (q.bitc == 4'h7) begin
                        n.ack_due = 1'b0;
                        if (!i2c) begin
                            n.bitc = 4'h0;  // SPI has no acknowledge slot.
                        end
                        unique case (q.phase)
                            csub_pkg::SP_ADDR: begin
                                // A foreign address idles the engine until the frame ends.
                                if (byte_in[7:1] == `CSUB_CHIP_ADDR) begin
                                    n.rw      = byte_in[0];
                                    n.ack_due = 1'b1;
                                    n.phase   = byte_in[0] ? csub_pkg::SP_DATA : csub_pkg::SP_MAP;
                                    s_rd      = byte_in[0];
                                end else begin
                                    n.phase = csub_pkg::SP_IDLE;
                                end
                            end
                            csub_pkg::SP_MAP: begin
                                n.map     = byte_in;
                                n.ack_due = 1'b1;
                                n.phase   = csub_pkg::SP_DATA;
                            end
                            csub_pkg::SP_DATA: begin
                                s_rd      = q.rw;
                                s_wr      = ~q.rw;
                                n.ack_due = ~q.rw;
                            end
                            default: begin
                                n.phase = csub_pkg::SP_IDLE;
                            end
                        endcase
                    end
                end
            end
            if (clk_f) begin
                if (i2c) begin
                    // Open drain: the pin is pulled low only to send a zero or an acknowledge.
                    if (q.bitc == 4'h8) begin
                        n.ser_oe = q.ack_due;
                    end else begin
                        n.ser_oe = q.rw & (q.phase == csub_pkg::SP_DATA) & ~q.nack & ~q.txsh[7];
                        n.txsh   = {q.txsh[6:0], 1'b0};
                    end
                end else begin
                    n.ser_out = q.txsh[7];
                    n.txsh    = {q.txsh[6:0], 1'b0};
                end
            end
        end
        if (i2c) begin
            n.ser_out = 1'b0;
        end

        // Receive path fills D; the block start realigns the bit pointer.
        if (on && rx_bit_valid_i) begin
            if (rx_block_first_i) begin
                ptr          = 9'h000;
                ev1[`CSUB_S1_REALIGN] = q.rx_aligned & (q.rxp != 9'h000);
                n.rx_aligned = 1'b1;
            end
            if (rx_block_first_i || q.rx_aligned) begin
                n.d_cs[ptr] = rx_cbit_i;
                n.d_us[ptr] = rx_ubit_i;
                if (ptr == `CSUB_LAST_BIT) begin
                    // Full D moves into E; fixed mode keeps the host's first five status bytes.
                    if (q.ctrl[`CSUB_CTRL_FIX5]) begin
                        n.e_cs[`CSUB_BUF_BITS-1:`CSUB_FIX5_BITS] = n.d_cs[`CSUB_BUF_BITS-1:`CSUB_FIX5_BITS];
                    end else begin
                        n.e_cs = n.d_cs;
                    end
                    // User data passes on by itself unless the host holds the user stage.
                    if (!q.ctrl[`CSUB_CTRL_UHOLD]) begin
                        n.e_us = n.d_us;
                    end
                    n.rxp             = 9'h000;
                    ev0[`CSUB_S0_DE]  = 1'b1;
                end else begin
                    n.rxp = ptr + 9'h001;
                end
            end
        end

        // Register access; control registers never depend on the master clocks.
        if (reg_wr_i) begin
            n = reg_write(n, reg_addr_i, reg_wdata_i, on);
            ev1[`CSUB_S1_REFUSED] = ev1[`CSUB_S1_REFUSED] | (in_win(reg_addr_i) & ~on);
        end
        n.rdata = reg_rd_i ? reg_read(q, reg_addr_i, on) : 8'h00;
        if (reg_rd_i) begin
            ev1[`CSUB_S1_REFUSED] = ev1[`CSUB_S1_REFUSED] | (in_win(reg_addr_i) & ~on);
        end
        // Serial access lands after the parallel one, so it wins a same-cycle collision.
        if (s_wr) begin
            n     = reg_write(n, q.map, byte_in, on);
            n.map = q.map + 8'h01;
        end
        if (s_rd) begin
            n.txsh = reg_read(q, q.map, on);
            n.map  = q.map + 8'h01;
        end
        if ((s_wr || s_rd) && in_win(q.map) && !on) begin
            ev1[`CSUB_S1_REFUSED] = 1'b1;
        end

        // Transmit path reads F; the last bit of a block reloads F from E.
        if (on && tx_bit_req_i) begin
            n.tx_c = q.f_cs[q.txp];
            n.tx_u = q.f_us[q.txp];
            if (q.txp == `CSUB_LAST_BIT) begin
                n.f_cs           = n.e_cs;
                n.f_us           = n.e_us;
                n.txp            = 9'h000;
                ev0[`CSUB_S0_EF] = 1'b1;
            end else begin
                n.txp = q.txp + 9'h001;
            end
        end

        // Stopped clocks freeze the stages and drop block alignment.
        if (!on) begin
            n.rxp        = 9'h000;
            n.txp        = 9'h000;
            n.rx_aligned = 1'b0;
        end

        // Hardware sets are applied last so they beat a clear in the same cycle.
        n.stat0 = n.stat0 | ev0;
        n.stat1 = n.stat1 | ev1;
        pend    = |(n.stat0 & n.en0) | |(n.stat1 & n.en1);
        // Output format: active high, active low, or open drain pulled low.
        unique case (n.irqfmt)
            `CSUB_IF_LOW: begin
                n.irq    = ~pend;
                n.irq_oe = 1'b1;
            end
            `CSUB_IF_OPEN: begin
                n.irq    = 1'b0;
                n.irq_oe = pend;
            end
            default: begin
                n.irq    = pend;
                n.irq_oe = 1'b1;
            end
        endcase
    end

    // Register the whole block state; reset empties every stage.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // Every output is a flip-flop of the state.
    assign reg_rdata_o = q.rdata;
    assign ser_io_o    = q.ser_out;
    assign ser_io_oe_o = q.ser_oe;
    assign tx_cbit_o   = q.tx_c;
    assign tx_ubit_o   = q.tx_u;
    assign irq_o       = q.irq;
    assign irq_oe_o    = q.irq_oe;

endmodule

// ---- testbench/csub_top_monitor.sv ----
// Port-level checker for the buffer block, bound into every csub_top instance.
// Assumes mclk_i is the only clock and arst_n_i the asynchronous low reset.
module csub_top_monitor (
    input wire logic       mclk_i,
    input wire logic       arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       ser_sel_n_i,
    input wire logic       ser_io_oe_o,
    input wire logic       i2c_mode_i,
    input wire logic       rclk_run_i,
    input wire logic       xclk_run_i,
    input wire logic       tx_bit_req_i,
    input wire logic       tx_cbit_o,
    input wire logic       tx_ubit_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Read data may only stand in the cycle after a read strobe.
    rdata_idle_a: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
        else $error("read data outside its slot");
    unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 8'hff |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // Control readback works whatever the master clocks do.
    ctrl_readback_a: assert property ((reg_wr_i && reg_addr_i == 8'h00) ##2 (reg_rd_i && reg_addr_i == 8'h00)
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h0f))
        else $error("control readback wrong");
    // The window is dead while the recovered clock is stopped.
    refused_read_a: assert property (!rclk_run_i [*8] ##0 (reg_rd_i && reg_addr_i >= 8'h20
        && reg_addr_i < 8'h50) |=> reg_rdata_o == 8'h00)
        else $error("window read while stopped");
    tx_hold_a: assert property (!$past(tx_bit_req_i) |-> $stable(tx_cbit_o) && $stable(tx_ubit_o))
        else $error("transmit bits moved without request");
    stopped_tx_a: assert property (!xclk_run_i [*8] ##0 tx_bit_req_i |=> $stable(tx_cbit_o))
        else $error("request served while stopped");
    spi_oe_idle_a: assert property ((!i2c_mode_i && ser_sel_n_i) [*8] |-> !ser_io_oe_o)
        else $error("data out driven while deselected");
    spi_oe_busy_a: assert property ((!i2c_mode_i && !ser_sel_n_i) [*8] |-> ser_io_oe_o)
        else $error("data out not driven while selected");

    win_read_c: cover property (reg_rd_i && reg_addr_i == 8'h21);
    spi_frame_c: cover property ($fell(ser_sel_n_i));
    tx_run_c: cover property (tx_bit_req_i && xclk_run_i);
endmodule

bind csub_top csub_top_monitor csub_top_monitor_i (.*);

// ---- testbench/csub_host_model.sv ----
// Host microcontroller driving the serial control port as an SPI master, and as an I2C master for one write task.
// Assumes the device samples on the rising serial clock and shifts out after the fall.
`include "csub_defines.svh"
module csub_host_model (
    output logic      ser_clk_o,
    output logic      ser_sel_n_o,
    output logic      ser_din_o,
    input  wire logic cdout_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands still low and select idles high outside SPI frames; an I2C write leaves the clock high.
    initial begin
        ser_clk_o = 1'b0;
        ser_sel_n_o = 1'b1;
        ser_din_o = 1'b1;
    end

    // One byte, most significant bit first; the host makes every clock edge itself.
    task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            ser_din_o = w[i];
            #62.5 ser_clk_o = 1'b1;
            r[i] = cdout_i;
            #62.5 ser_clk_o = 1'b0;
        end
    endtask

    // Select low opens a frame with the chip address byte.
    task automatic open(input logic rw);
        logic [7:0] r;
        ser_sel_n_o = 1'b0;
        #125 xbyte({`CSUB_CHIP_ADDR, rw}, r);
    endtask

    // A released data line shows the inverse of its last value, never a stale one.
    task automatic close();
        #125 ser_sel_n_o = 1'b1;
        ser_din_o = ~ser_din_o;
        #1000;
    endtask

    // Write one byte to a map address.
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        open(1'b0);
        xbyte(a, r);
        xbyte(d, r);
        close();
    endtask

    // I2C write of one byte to a map address; data moves only while the clock is low, except for the start and stop conditions.
    task automatic iput(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        ser_clk_o = 1'b1;
        ser_din_o = 1'b1;
        #1000 ser_din_o = 1'b0;
        #125 ser_clk_o = 1'b0;
        for (int k = 0; k < 3; k++) begin
            xbyte(k == 0 ? {`CSUB_CHIP_ADDR, 1'b0} : (k == 1 ? a : d), r);
            ser_din_o = 1'b1;  // Release the line for the acknowledge slot.
            #62.5 ser_clk_o = 1'b1;
            #62.5 ser_clk_o = 1'b0;
        end
        ser_din_o = 1'b0;
        #62.5 ser_clk_o = 1'b1;
        #62.5 ser_din_o = 1'b1;  // Data rising with the clock high ends the frame.
        #1000;
    endtask

    // Set the map address, then read one byte back in a second frame.
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        open(1'b0);
        xbyte(a, r);
        close();
        open(1'b1);
        xbyte(8'h00, d);
        close();
    endtask
endmodule

// ---- testbench/csub_top_tb_top.sv ----
// Self-checking bench: register port, receive fill, SPI access and transmit drain.
// Assumes the host model and the bound monitor are compiled alongside.
module csub_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] HOST_BYTE = 8'h5a;  // Byte the host writes into the user stage.
    logic       mclk_i, arst_n_i, reg_wr_i, reg_rd_i, i2c_mode_i, ser_io_i, rclk_run_i, xclk_run_i;
    logic       rx_bit_valid_i, rx_block_first_i, rx_cbit_i, rx_ubit_i, tx_bit_req_i;
    logic       ser_clk_i, ser_sel_n_i, ser_din_i, ser_io_o, ser_io_oe_o, tx_cbit_o, tx_ubit_o, irq_o, irq_oe_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
    int         failures, samples_checked;

    csub_top csub_top_i (.*);
    csub_host_model csub_host_model_i (.ser_clk_o(ser_clk_i), .ser_sel_n_o(ser_sel_n_i),
        .ser_din_o(ser_din_i), .cdout_i(ser_io_o));
    // In I2C mode the host data pin and the device pull-down share one pulled-up line.
    assign ser_io_i = ser_din_i & ~ser_io_oe_o;

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    // One-cycle read strobe; data is looked at in the following cycle only.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask

    // One transmit request, then the bit pair it produced.
    task automatic txq(input logic ec, input logic eu);
        @(posedge mclk_i);
        tx_bit_req_i <= 1'b1;
        @(posedge mclk_i);
        tx_bit_req_i <= 1'b0;
        #1 chk({6'h00, tx_cbit_o, tx_ubit_o}, {6'h00, ec, eu});
    endtask

    // One receive block: status bit is i[0], user bit is i[1], both inverted on request.
    task automatic rxblk(input logic inv);
        for (int i = 0; i < 384; i++) begin
            @(posedge mclk_i);
            rx_bit_valid_i <= 1'b1;
            rx_block_first_i <= (i == 0);
            rx_cbit_i <= i[0] ^ inv;
            rx_ubit_i <= i[1] ^ inv;
            @(posedge mclk_i);
            rx_bit_valid_i <= 1'b0;
        end
    endtask

    // A hang counts as a mismatch.
    initial begin
        #400us failures++;
        summarize();
    end

    initial begin
        {arst_n_i, reg_wr_i, reg_rd_i, i2c_mode_i, rclk_run_i, xclk_run_i} = 6'h00;
        {rx_bit_valid_i, rx_block_first_i, rx_cbit_i, rx_ubit_i, tx_bit_req_i} = 5'h00;
        {reg_addr_i, reg_wdata_i} = 16'h0000;
        failures = 0;
        samples_checked = 0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        rd(8'h00, 8'h00);
        rd(8'hff, 8'h00);
        chk({7'h00, irq_oe_o}, 8'h01);
        txq(1'b0, 1'b0);
        rd(8'h20, 8'h00);
        rd(8'h05, 8'h01);
        wr(8'h06, 8'h01);
        repeat (2) @(posedge mclk_i);
        #1 chk({7'h00, irq_o}, 8'h01);
        wr(8'h07, 8'h01);
        repeat (2) @(posedge mclk_i);
        #1 chk({7'h00, irq_o}, 8'h00);
        rclk_run_i <= 1'b1;
        xclk_run_i <= 1'b1;
        wr(8'h00, 8'h01);
        repeat (8) @(posedge mclk_i);
        rd(8'h08, 8'h07);
        rxblk(1'b0);
        rd(8'h02, 8'h01);
        rd(8'h20, 8'haa);
        rd(8'h4f, 8'haa);
        wr(8'h00, 8'h03);
        rd(8'h00, 8'h03);
        rd(8'h20, 8'hcc);
        csub_host_model_i.put(8'h21, HOST_BYTE);
        rd(8'h21, HOST_BYTE);
        csub_host_model_i.get(8'h21, v);
        chk(v, HOST_BYTE);
        // First pass drains the empty last stage, second pass the reloaded one.
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 384; i++) begin
                txq(p ? i[0] : 1'b0, p ? ((i >= 8 && i < 16) ? HOST_BYTE[i - 8] : i[1]) : 1'b0);
            end
            if (p == 0) rd(8'h02, 8'h03);
        end
        i2c_mode_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        csub_host_model_i.iput(8'h22, 8'h3c);
        rd(8'h22, 8'h3c);
        // Fixed first bytes and held user stage must survive an inverted block.
        wr(8'h00, 8'h0d);
        wr(8'h20, 8'h96);
        rxblk(1'b1);
        rd(8'h20, 8'h96);
        rd(8'h25, 8'h55);
        wr(8'h00, 8'h0f);
        rd(8'h20, 8'hcc);
        wr(8'h01, 8'h01);
        repeat (2) @(posedge mclk_i);
        #1 chk({6'h00, irq_o, irq_oe_o}, 8'h03);
        summarize();
    end
endmodule
